//--- hdl/host_port_regs.svh
// register map, field positions and timing constants of the host port
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

`define HP_ADDR_W 8
`define HP_DATA_W 16
`define HP_NUM_REGS 256
`define HP_SWCTRL_ADDR 8'h00
`define HP_SWRST_BIT 0
`define HP_REG_RESET 16'h0000
`define HP_PLL_LOCK_NS 60
`define HP_CLK_PERIOD_NS 40
`define HP_PLL_LOCK_CYC \
    ((`HP_PLL_LOCK_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)

`endif

//--- hdl/host_port_pkg.sv
// types shared by the host port design files
package host_port_pkg;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } access_state_t;
endpackage

//--- hdl/sync_2ff.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage is read only by the second stage
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule

//--- hdl/host_register_port.sv
// asynchronous parallel host port with register file and reset control
// Summary of operation
// - 8-bit word address, 16-bit data, low strobes
// - read starts when select and read low, write high
// - read ends, data released on strobe high
// - write stores data when select, write low, read high
// - write ends when select or write high
// - software reset bit restores register defaults
// - software reset bit clears on next clock
// - hardware reset holds PLL and reset bit
// - wait 60 ns for PLL lock
`timescale 1ns/100ps
`include "host_port_regs.svh"
module host_register_port #(
    parameter int ADDR_W = `HP_ADDR_W,
    parameter int DATA_W = `HP_DATA_W,
    parameter int NUM_REGS = `HP_NUM_REGS,
    parameter logic [`HP_ADDR_W-1:0] SWCTRL_ADDR = `HP_SWCTRL_ADDR,
    parameter int SWRST_BIT = `HP_SWRST_BIT,
    parameter int LOCK_CYC = `HP_PLL_LOCK_CYC
) (
    // clock and hardware reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // host bus pins
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_sel_n_i,
    input wire logic cpu_rd_n_i,
    input wire logic cpu_wr_n_i,
    input wire logic [DATA_W-1:0] cpu_data_i,
    output logic [DATA_W-1:0] cpu_data_o,
    output logic cpu_data_oe_o,
    // core status
    output logic pll_locked_o,
    output logic sw_reset_o
);
    localparam int CNT_W = $clog2(LOCK_CYC + 1);

    logic [2:0] strb_sync;
    logic [ADDR_W-1:0] addr_sync;
    logic [DATA_W-1:0] wdata_sync;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic rd_act;
    logic wr_act;

    logic [DATA_W-1:0] regs_mem [NUM_REGS];
    logic [DATA_W-1:0] wr_data_reg;
    logic [DATA_W-1:0] wr_data_next;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] wr_addr_next;
    logic wr_go_reg;

    host_port_pkg::access_state_t state_reg;
    host_port_pkg::access_state_t state_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic oe_reg;
    logic oe_next;
    logic wr_go_next;
    logic swrst_reg;
    logic swrst_next;
    logic [CNT_W-1:0] lock_cnt_reg;
    logic [CNT_W-1:0] lock_cnt_next;
    logic locked_reg;
    logic locked_next;

    // strobes idle high, matching the pin pull-ups
    sync_2ff #(
        .WIDTH(3),
        .RESET_VAL(3'h7)
    ) u_strb_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i({cpu_sel_n_i, cpu_rd_n_i, cpu_wr_n_i}),
        .sync_o(strb_sync)
    );

    // address and data are stable around the strobe, still synchronised
    sync_2ff #(
        .WIDTH(ADDR_W + DATA_W),
        .RESET_VAL('0)
    ) u_bus_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i({cpu_addr_i, cpu_data_i}),
        .sync_o({addr_sync, wdata_sync})
    );

    // access qualifiers, the later falling strobe starts the access
    assign sel_n = strb_sync[2];
    assign rd_n = strb_sync[1];
    assign wr_n = strb_sync[0];
    assign rd_act = !sel_n && !rd_n && wr_n;
    assign wr_act = !sel_n && !wr_n && rd_n;

    // access state machine, the core is only served once locked
    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        oe_next = 1'b0;
        wr_go_next = 1'b0;
        case (state_reg)
            host_port_pkg::ACC_IDLE: begin
                if (locked_reg && rd_act) begin
                    state_next = host_port_pkg::ACC_READ;
                    rdata_next = regs_mem[addr_sync];
                    oe_next = 1'b1;
                end else if (locked_reg && wr_act) begin
                    state_next = host_port_pkg::ACC_WRITE;
                    wr_go_next = 1'b1; // single write per strobe
                end
            end
            host_port_pkg::ACC_READ: begin
                if (rd_act) begin
                    rdata_next = regs_mem[addr_sync];
                    oe_next = 1'b1;
                end else begin
                    state_next = host_port_pkg::ACC_IDLE;
                end
            end
            host_port_pkg::ACC_WRITE: begin
                if (sel_n || wr_n) begin
                    state_next = host_port_pkg::ACC_IDLE;
                end
            end
            default: begin
                state_next = host_port_pkg::ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= host_port_pkg::ACC_IDLE;
            rdata_reg <= '0;
            oe_reg <= 1'b0;
            wr_go_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            oe_reg <= oe_next;
            wr_go_reg <= wr_go_next;
        end
    end

    // write address and data held from the write pulse onwards
    always_comb begin
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        if (wr_go_next) begin
            wr_addr_next = addr_sync;
            wr_data_next = wdata_sync;
        end
    end

    // no reset needed: only read while the write pulse stands
    always_ff @(posedge clk_sys_i) begin
        wr_addr_reg <= wr_addr_next;
        wr_data_reg <= wr_data_next;
    end

    // software reset bit, set by a write, cleared the next clock
    always_comb begin
        swrst_next = 1'b0; // self clearing
        if (wr_go_reg && wr_addr_reg == SWCTRL_ADDR &&
            wr_data_reg[SWRST_BIT]) begin
            swrst_next = 1'b1;
        end
    end

    // hardware reset holds the bit cleared
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            swrst_reg <= 1'b0;
        end else begin
            swrst_reg <= swrst_next;
        end
    end

    // register file, cleared by software reset; reset bit reads zero
    always_ff @(posedge clk_sys_i) begin
        if (swrst_reg) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_mem[i] <= `HP_REG_RESET;
            end
        end else if (wr_go_reg) begin
            regs_mem[wr_addr_reg] <= wr_data_reg;
            if (wr_addr_reg == SWCTRL_ADDR) begin
                regs_mem[wr_addr_reg][SWRST_BIT] <= 1'b0;
            end
        end
    end

    // lock wait after hardware reset release
    always_comb begin
        lock_cnt_next = lock_cnt_reg;
        locked_next = locked_reg;
        if (!locked_reg) begin
            if (lock_cnt_reg == CNT_W'(LOCK_CYC - 1)) begin
                locked_next = 1'b1;
            end else begin
                lock_cnt_next = lock_cnt_reg + 1'b1;
            end
        end
    end

    // 20 ns minimum pulse is caught by the asynchronous clear
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_cnt_reg <= '0;
            locked_reg <= 1'b0;
        end else begin
            lock_cnt_reg <= lock_cnt_next;
            locked_reg <= locked_next;
        end
    end

    // outputs straight from flip-flops
    assign cpu_data_o = rdata_reg;
    assign cpu_data_oe_o = oe_reg;
    assign pll_locked_o = locked_reg;
    assign sw_reset_o = swrst_reg;
endmodule

//--- verification/host_port_properties.sv
// pin-level checks of the host register port
`timescale 1ns/100ps
module host_port_properties #(
    parameter logic [7:0] SWCTRL_ADDR = 8'h00,
    parameter int SWRST_BIT = 0,
    parameter int LOCK_CYC = 2
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // host pins and status
    input wire logic [7:0] cpu_addr_i,
    input wire logic cpu_sel_n_i,
    input wire logic cpu_rd_n_i,
    input wire logic cpu_wr_n_i,
    input wire logic [15:0] cpu_data_i,
    input wire logic cpu_data_oe_o,
    input wire logic pll_locked_o,
    input wire logic sw_reset_o
);
    logic [3:0] lock_cnt_reg;
    logic rd_acc;
    logic wr_acc;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // edges since reset release, saturating so it never wraps
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_cnt_reg <= 4'h0;
        end else if (lock_cnt_reg != 4'hF) begin
            lock_cnt_reg <= lock_cnt_reg + 4'h1;
        end
    end
    // qualified accesses as seen on the pins
    assign rd_acc = !cpu_sel_n_i && !cpu_rd_n_i && cpu_wr_n_i && pll_locked_o;
    assign wr_acc = !cpu_sel_n_i && !cpu_wr_n_i && cpu_rd_n_i;
    // five edges cover the two synchroniser stages and the output flop
    sequence s_rd_held;
        rd_acc [*5];
    endsequence
    sequence s_rd_gone;
        !rd_acc [*5];
    endsequence
    sequence s_wr_held;
        (!cpu_sel_n_i && !cpu_wr_n_i) [*5];
    endsequence
    property p_rd_oe;
        s_rd_held |-> cpu_data_oe_o;
    endproperty
    property p_rd_end;
        s_rd_gone |-> !cpu_data_oe_o;
    endproperty
    property p_rd_stands;
        rd_acc && cpu_data_oe_o |=> cpu_data_oe_o;
    endproperty
    property p_wr_no_oe;
        s_wr_held |-> !cpu_data_oe_o;
    endproperty
    property p_sw_once;
        sw_reset_o |=> !sw_reset_o;
    endproperty
    // the pulse follows the write by the synchroniser and two flops
    property p_sw_cause;
        sw_reset_o |-> $past(wr_acc && cpu_addr_i == SWCTRL_ADDR
            && cpu_data_i[SWRST_BIT], 2);
    endproperty
    property p_lock_wait;
        lock_cnt_reg < LOCK_CYC |-> !pll_locked_o && !sw_reset_o;
    endproperty
    property p_lock_on;
        lock_cnt_reg >= LOCK_CYC |-> pll_locked_o;
    endproperty
    // the bus is never driven before the clock is trusted
    property p_oe_locked;
        cpu_data_oe_o |-> pll_locked_o;
    endproperty
    a_rd_oe: assert property (p_rd_oe)
        else $error("no read drive");
    a_rd_end: assert property (p_rd_end)
        else $error("bus held");
    a_rd_stands: assert property (p_rd_stands)
        else $error("oe dropped");
    a_wr_no_oe: assert property (p_wr_no_oe)
        else $error("oe in write");
    a_sw_once: assert property (p_sw_once)
        else $error("reset bit held");
    a_sw_cause: assert property (p_sw_cause)
        else $error("stray reset");
    a_lock_wait: assert property (p_lock_wait)
        else $error("early lock");
    a_lock_on: assert property (p_lock_on)
        else $error("no lock");
    a_oe_locked: assert property (p_oe_locked)
        else $error("bus driven before lock");
endmodule
bind host_register_port host_port_properties #(.SWCTRL_ADDR(SWCTRL_ADDR),
    .SWRST_BIT(SWRST_BIT), .LOCK_CYC(LOCK_CYC)) u_props (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cpu_addr_i(cpu_addr_i),
    .cpu_sel_n_i(cpu_sel_n_i), .cpu_rd_n_i(cpu_rd_n_i),
    .cpu_wr_n_i(cpu_wr_n_i), .cpu_data_i(cpu_data_i),
    .cpu_data_oe_o(cpu_data_oe_o), .pll_locked_o(pll_locked_o),
    .sw_reset_o(sw_reset_o));

//--- verification/host_cpu_model.sv
// host processor model on the asynchronous register bus
`timescale 1ns/100ps
module host_cpu_model (
    // clock and device side
    input wire logic clk_sys_i,
    input wire logic [15:0] dout_i,
    input wire logic oe_i,
    // bus pins
    output logic [7:0] addr_o,
    output logic sel_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [15:0] bus_o
);
    logic [15:0] hdata;
    logic hdrv;
    // released bus shows the inverted last word so no stale value passes
    assign bus_o = oe_i ? dout_i : hdrv ? hdata : ~hdata;
    // idle strobes high as through the pull-ups
    initial begin
        {sel_n_o, rd_n_o, wr_n_o, hdrv} = 4'hE;
        addr_o = 8'h00;
        hdata = 16'h0000;
    end
    // one access; strobes held 8 cycles, then 4 idle cycles of dead time
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q, output bit ok);
        @(negedge clk_sys_i);
        addr_o = a;
        hdata = d;
        hdrv = r;
        {sel_n_o, rd_n_o, wr_n_o} = {1'b0, r, w};
        ok = r;
        q = 16'h0000;
        // sample on the falling edge, where the device outputs have settled
        repeat (8) begin
            @(negedge clk_sys_i);
            if (!r && oe_i === 1'b1) begin
                ok = 1'b1;
                q = bus_o;
            end
        end
        {sel_n_o, rd_n_o, wr_n_o, hdrv} = 4'hE;
        repeat (4) @(negedge clk_sys_i);
    endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the host register port
`timescale 1ns/100ps
module tb;
    logic clk_sys_i;
    logic arst_n_i;
    logic [7:0] addr;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic [15:0] bus;
    logic [15:0] dout;
    logic oe;
    logic pll_locked_o;
    logic sw_reset_o;
    logic [15:0] q;
    bit ok;
    int fails;
    int check_count;
    int pulses;
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    host_register_port #(.LOCK_CYC(2)) u_dut (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .cpu_addr_i(addr), .cpu_sel_n_i(sel_n),
        .cpu_rd_n_i(rd_n), .cpu_wr_n_i(wr_n), .cpu_data_i(bus),
        .cpu_data_o(dout), .cpu_data_oe_o(oe), .pll_locked_o(pll_locked_o),
        .sw_reset_o(sw_reset_o));
    host_cpu_model u_host (.clk_sys_i(clk_sys_i), .dout_i(dout), .oe_i(oe),
        .addr_o(addr), .sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .bus_o(bus));
    // count software reset pulses
    always @(negedge clk_sys_i) begin
        if (sw_reset_o === 1'b1) begin
            pulses++;
        end
    end
    task automatic end_of_test;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input bit good, input string msg);
        check_count++;
        if (!good) begin
            fails++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.acc(1'b1, 1'b0, a, d, q, ok);
    endtask
    // a read that never drives the bus is a hang and ends the run
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        u_host.acc(1'b0, 1'b1, a, 16'h0000, q, ok);
        check(ok && q === e, "read data");
        check(oe === 1'b0, "bus not released");
        if (!ok) end_of_test();
    endtask
    task automatic t_reset;
        check({oe, pll_locked_o, sw_reset_o} === 3'h0, "reset outs");
        @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        @(negedge clk_sys_i);
        check(pll_locked_o === 1'b0, "lock too soon");
        repeat (3) @(negedge clk_sys_i);
        check(pll_locked_o === 1'b1, "no lock");
    endtask
    task automatic t_rw;
        wr(8'h55, 16'hA5C3);
        wr(8'hFF, 16'h5A3C);
        rd(8'h55, 16'hA5C3);
        rd(8'hFF, 16'h5A3C);
        u_host.acc(1'b0, 1'b0, 8'h55, 16'hFFFF, q, ok);
        check(!ok, "drove bus with both strobes");
        rd(8'h55, 16'hA5C3);
    endtask
    task automatic t_swrst;
        pulses = 0;
        wr(8'h00, 16'h8000);
        rd(8'h00, 16'h8000);
        wr(8'h00, 16'h0001);
        check(pulses == 1, "reset pulse count");
        rd(8'h55, 16'h0000);
        rd(8'hFF, 16'h0000);
        rd(8'h00, 16'h0000);
    endtask
    // hardware reset in mid-run: outputs drop, lock waits again
    task automatic t_hw_reset;
        wr(8'h33, 16'h1234);
        arst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        t_reset();
        rd(8'h33, 16'h1234);
    endtask
    initial begin
        arst_n_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        t_reset();
        t_rw();
        t_swrst();
        t_hw_reset();
        end_of_test();
    end
endmodule
